/* File: core/ffma_defines.vh */
// Register map, field positions and reset values of the fault mask aggregator
`ifndef FFMA_DEFINES_VH
`define FFMA_DEFINES_VH

// ----------------------------------------------------------------------------
// Register indices and addressing
// ----------------------------------------------------------------------------
`define FFMA_IDX_INTEG_MASK   8'h49
`define FFMA_IDX_OCC_MASK     8'h4A
`define FFMA_IDX_PIN_GATE     8'h4B
`define FFMA_IDX_STATUS       8'h50
`define FFMA_IDX_PIN_CFG      8'h51
`define FFMA_ADDR_W           10
`define FFMA_DATA_W           32
`define FFMA_REG_W            16

// ----------------------------------------------------------------------------
// Writable bits and reset values
// ----------------------------------------------------------------------------
`define FFMA_INTEG_WMASK      16'hE800
`define FFMA_OCC_WMASK        16'h000F
`define FFMA_PIN_WMASK        16'h7F80
`define FFMA_INTEG_RST        16'h0000
`define FFMA_OCC_RST          16'h0000
`define FFMA_PIN_RST          16'h0780
`define FFMA_CFG_RST          1'h0

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define FFMA_B_SEC1           15
`define FFMA_B_SEC2           14
`define FFMA_B_SEC3           13
`define FFMA_B_MEM            11
`define FFMA_B_A_HI           3
`define FFMA_B_A_LO           2
`define FFMA_B_B_HI           1
`define FFMA_B_B_LO           0
`define FFMA_B_RAIL           14
`define FFMA_B_TIME           13
`define FFMA_B_INTEG          12
`define FFMA_B_OCC            11
`define FFMA_B_SCHK           10
`define FFMA_B_SIDLE          9
`define FFMA_B_SEDGE          8
`define FFMA_B_ACC            7
`define FFMA_B_FAULT_OUT      0

`endif

/* File: core/ffma_top.v */
// Fault flag masking and aggregation with an Avalon-MM register slave
`timescale 1ns/100ps
`include "ffma_defines.vh"

module ffma_top
(
    // Clock, reset, enable
    input  wire        CLK_SYS,
    input  wire        NRST,
    input  wire        CE,
    // Avalon-MM slave
    input  wire [9:0]  AVS_ADDRESS,
    input  wire        AVS_READ,
    input  wire        AVS_WRITE,
    input  wire [31:0] AVS_WRITEDATA,
    input  wire [3:0]  AVS_BYTEENABLE,
    output reg  [31:0] AVS_READDATA,
    output reg         AVS_WAITREQUEST,
    output reg  [1:0]  AVS_RESPONSE,
    // Integrity sources, active high
    input  wire        CFG_SECTION_ONE_CHECK_ERR,
    input  wire        CFG_SECTION_TWO_CHECK_ERR,
    input  wire        CFG_SECTION_THREE_CHECK_ERR,
    input  wire        MEMORY_IMAGE_CHECK_ERR,
    // Overcurrent comparator sources, active high
    input  wire        CONV_A_HIGH_TRIP,
    input  wire        CONV_A_LOW_TRIP,
    input  wire        CONV_B_HIGH_TRIP,
    input  wire        CONV_B_LOW_TRIP,
    // Other status-level sources, active high
    input  wire        POWER_RAIL_ERR,
    input  wire        TIMEBASE_ERR,
    input  wire        SERIAL_CHECK_ERR,
    input  wire        SERIAL_IDLE_EXPIRY,
    input  wire        SERIAL_EDGE_COUNT_ERR,
    input  wire        ILLEGAL_ACCESS_ERR,
    // Summary flags and alarm pin
    output reg         INTEGRITY_SUMMARY_FLAG,
    output reg         OVERCURRENT_SUMMARY_FLAG,
    output reg         SHARED_ALARM_PIN
);

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    // Word-index decode, shared by the read and write paths
    function [7:0] word_idx;
        input [9:0] addr;
        begin
            word_idx = addr[9:2];
        end
    endfunction

    // Byte-lane merge restricted to the writable bits of a register
    function [15:0] lane_merge;
        input [15:0] old_val;
        input [31:0] wdata;
        input [3:0]  be;
        input [15:0] wmask;
        reg   [15:0] lanes;
        begin
            lanes = {{8{be[1]}}, {8{be[0]}}};
            lane_merge = (old_val & ~(lanes & wmask)) | (wdata[15:0] & lanes & wmask);
        end
    endfunction

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    reg  [15:0] integ_mask_q;
    reg  [15:0] occ_mask_q;
    reg  [15:0] pin_gate_q;
    reg         fault_out_en_q;
    reg         ack_q;
    wire [7:0]  idx;
    wire        req;
    wire        hit;
    wire        integ_d;
    wire        occ_d;
    wire        pin_d;
    wire [15:0] status_w;

    assign idx = word_idx(AVS_ADDRESS);
    assign req = (AVS_READ | AVS_WRITE) & ~ack_q;
    assign hit = (idx == `FFMA_IDX_INTEG_MASK) | (idx == `FFMA_IDX_OCC_MASK) |
                 (idx == `FFMA_IDX_PIN_GATE) | (idx == `FFMA_IDX_STATUS) |
                 (idx == `FFMA_IDX_PIN_CFG);

    // ------------------------------------------------------------------------
    // Aggregation
    // ------------------------------------------------------------------------
    // Integrity summary from unmasked check errors
    assign integ_d =
        (CFG_SECTION_ONE_CHECK_ERR   & ~integ_mask_q[`FFMA_B_SEC1]) |
        (CFG_SECTION_TWO_CHECK_ERR   & ~integ_mask_q[`FFMA_B_SEC2]) |
        (CFG_SECTION_THREE_CHECK_ERR & ~integ_mask_q[`FFMA_B_SEC3]) |
        (MEMORY_IMAGE_CHECK_ERR      & ~integ_mask_q[`FFMA_B_MEM]);

    // Overcurrent summary from unmasked comparator trips
    assign occ_d =
        (CONV_A_HIGH_TRIP & ~occ_mask_q[`FFMA_B_A_HI]) |
        (CONV_A_LOW_TRIP  & ~occ_mask_q[`FFMA_B_A_LO]) |
        (CONV_B_HIGH_TRIP & ~occ_mask_q[`FFMA_B_B_HI]) |
        (CONV_B_LOW_TRIP  & ~occ_mask_q[`FFMA_B_B_LO]);

    // Pin takes the registered summaries so it lines up with status reads
    assign pin_d = fault_out_en_q & (
        (POWER_RAIL_ERR           & ~pin_gate_q[`FFMA_B_RAIL])  |
        (TIMEBASE_ERR             & ~pin_gate_q[`FFMA_B_TIME])  |
        (INTEGRITY_SUMMARY_FLAG   & ~pin_gate_q[`FFMA_B_INTEG]) |
        (OVERCURRENT_SUMMARY_FLAG & ~pin_gate_q[`FFMA_B_OCC])   |
        (SERIAL_CHECK_ERR         & ~pin_gate_q[`FFMA_B_SCHK])  |
        (SERIAL_IDLE_EXPIRY       & ~pin_gate_q[`FFMA_B_SIDLE]) |
        (SERIAL_EDGE_COUNT_ERR    & ~pin_gate_q[`FFMA_B_SEDGE]) |
        (ILLEGAL_ACCESS_ERR       & ~pin_gate_q[`FFMA_B_ACC]));

    // Raw sources stay visible regardless of masks
    assign status_w = {POWER_RAIL_ERR, TIMEBASE_ERR, INTEGRITY_SUMMARY_FLAG,
                       OVERCURRENT_SUMMARY_FLAG, SERIAL_CHECK_ERR, SERIAL_IDLE_EXPIRY,
                       SERIAL_EDGE_COUNT_ERR, ILLEGAL_ACCESS_ERR,
                       CFG_SECTION_ONE_CHECK_ERR, CFG_SECTION_TWO_CHECK_ERR,
                       CFG_SECTION_THREE_CHECK_ERR, MEMORY_IMAGE_CHECK_ERR,
                       CONV_A_HIGH_TRIP, CONV_A_LOW_TRIP,
                       CONV_B_HIGH_TRIP, CONV_B_LOW_TRIP};

    // Summary and pin registers
    always @(posedge CLK_SYS or negedge NRST)
    begin
        if (!NRST)
        begin
            INTEGRITY_SUMMARY_FLAG   <= 1'b0;
            OVERCURRENT_SUMMARY_FLAG <= 1'b0;
            SHARED_ALARM_PIN         <= 1'b0;
        end
        else if (CE)
        begin
            INTEGRITY_SUMMARY_FLAG   <= integ_d;
            OVERCURRENT_SUMMARY_FLAG <= occ_d;
            SHARED_ALARM_PIN         <= pin_d;
        end
    end

    // ------------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------------
    // Reserved bits are never stored, so they cannot read back as one
    always @(posedge CLK_SYS or negedge NRST)
    begin
        if (!NRST)
        begin
            integ_mask_q   <= `FFMA_INTEG_RST;
            occ_mask_q     <= `FFMA_OCC_RST;
            pin_gate_q     <= `FFMA_PIN_RST;
            fault_out_en_q <= `FFMA_CFG_RST;
        end
        else if (CE && req && AVS_WRITE)
        begin
            if (idx == `FFMA_IDX_INTEG_MASK)
                integ_mask_q <= lane_merge(integ_mask_q, AVS_WRITEDATA, AVS_BYTEENABLE,
                                           `FFMA_INTEG_WMASK);
            if (idx == `FFMA_IDX_OCC_MASK)
                occ_mask_q <= lane_merge(occ_mask_q, AVS_WRITEDATA, AVS_BYTEENABLE,
                                         `FFMA_OCC_WMASK);
            if (idx == `FFMA_IDX_PIN_GATE)
                pin_gate_q <= lane_merge(pin_gate_q, AVS_WRITEDATA, AVS_BYTEENABLE,
                                         `FFMA_PIN_WMASK);
            if (idx == `FFMA_IDX_PIN_CFG && AVS_BYTEENABLE[0])
                fault_out_en_q <= AVS_WRITEDATA[`FFMA_B_FAULT_OUT];
        end
    end

    // ------------------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------------------
    // One wait cycle per access while CE is high; answer is registered so outputs are flop-driven
    always @(posedge CLK_SYS or negedge NRST)
    begin
        if (!NRST)
        begin
            ack_q           <= 1'b0;
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA    <= 32'h00000000;
            AVS_RESPONSE    <= 2'h0;
        end
        else if (CE)
        begin
            ack_q           <= req;
            AVS_WAITREQUEST <= ~req;
            AVS_RESPONSE    <= (req && !hit) ? 2'h3 : 2'h0;
            if (req && AVS_READ)
            begin
                case (idx)
                    `FFMA_IDX_INTEG_MASK: AVS_READDATA <= {16'h0000, integ_mask_q};
                    `FFMA_IDX_OCC_MASK:   AVS_READDATA <= {16'h0000, occ_mask_q};
                    `FFMA_IDX_PIN_GATE:   AVS_READDATA <= {16'h0000, pin_gate_q};
                    `FFMA_IDX_STATUS:     AVS_READDATA <= {16'h0000, status_w};
                    `FFMA_IDX_PIN_CFG:    AVS_READDATA <= {31'h00000000, fault_out_en_q};
                    default:              AVS_READDATA <= 32'h00000000;
                endcase
            end
            else
                AVS_READDATA <= 32'h00000000;
        end
    end

endmodule // ffma_top

/* File: dv/ffma_props.sv */
// Port checks of the fault mask aggregator
`timescale 1ns/100ps
module ffma_props
(
    // Clock, reset, bus
    input wire        CLK_SYS,
    input wire        NRST,
    input wire        CE,
    input wire        AVS_READ,
    input wire        AVS_WRITE,
    input wire [31:0] AVS_READDATA,
    input wire        AVS_WAITREQUEST,
    input wire [1:0]  AVS_RESPONSE,
    // Comparator trips and their summary
    input wire        CONV_A_HIGH_TRIP,
    input wire        CONV_A_LOW_TRIP,
    input wire        CONV_B_HIGH_TRIP,
    input wire        CONV_B_LOW_TRIP,
    input wire        OVERCURRENT_SUMMARY_FLAG
);
    // ----------
    // Properties
    // ----------
    // Masks are internal, so the flag is only tied to some trip a cycle before
    wire req = AVS_READ | AVS_WRITE;
    wire occ_any = CONV_A_HIGH_TRIP | CONV_A_LOW_TRIP | CONV_B_HIGH_TRIP | CONV_B_LOW_TRIP;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);
    property p_take; req & AVS_WAITREQUEST & CE |=> !AVS_WAITREQUEST; endproperty
    a_take: assert property (p_take) else $error("request not answered");
    property p_one; !AVS_WAITREQUEST & CE |=> AVS_WAITREQUEST; endproperty
    a_one: assert property (p_one) else $error("answer longer than one cycle");
    property p_rdz; AVS_WAITREQUEST |-> AVS_READDATA == 32'h0; endproperty
    a_rdz: assert property (p_rdz) else $error("read data outside answer");
    property p_rsp0; AVS_WAITREQUEST |-> AVS_RESPONSE == 2'h0; endproperty
    a_rsp0: assert property (p_rsp0) else $error("response outside answer");
    property p_rsp; !AVS_WAITREQUEST |-> AVS_RESPONSE == 2'h0 | AVS_RESPONSE == 2'h3; endproperty
    a_rsp: assert property (p_rsp) else $error("illegal response code");
    property p_dec; !AVS_WAITREQUEST & AVS_RESPONSE == 2'h3 |-> AVS_READDATA == 32'h0; endproperty
    a_dec: assert property (p_dec) else $error("decode error with data");
    // A frozen clock enable holds the flag, so only a rise is tied to a trip
    property p_occ; $rose(OVERCURRENT_SUMMARY_FLAG) |-> $past(occ_any); endproperty
    a_occ: assert property (p_occ) else $error("summary without trip");
    property p_occ0; !occ_any & CE |=> !OVERCURRENT_SUMMARY_FLAG; endproperty
    a_occ0: assert property (p_occ0) else $error("summary left high");
    // Main scenarios
    cover property (!AVS_WAITREQUEST & AVS_RESPONSE == 2'h3);
    cover property (AVS_WRITE & !AVS_WAITREQUEST);
    cover property (OVERCURRENT_SUMMARY_FLAG);
    cover property (!CE & OVERCURRENT_SUMMARY_FLAG);
endmodule // ffma_props
bind ffma_top ffma_props u_ffma_props (.*);

/* File: dv/ffma_host.sv */
// Host register master model for the fault mask aggregator
`timescale 1ns/100ps
module ffma_host
(
    // Clock
    input  wire        clk,
    // Avalon-MM master side
    output reg  [9:0]  adr = 10'h0,
    output reg         rd = 1'b0,
    output reg         wr = 1'b0,
    output reg  [31:0] wd = 32'h0,
    input  wire [31:0] rdat,
    input  wire        wreq,
    input  wire [1:0]  resp,
    // High after a transfer that got no answer
    output reg         tmo = 1'b0
);
    // ----------
    // Transfers
    // ----------
    // Request held until waitrequest is sampled low or 40 cycles pass; read and write drop, address and
    // write data flip so stale values never pass for fresh ones
    task xfer(input w, input [9:0] a, input [31:0] d, output [31:0] q, output [1:0] r);
        integer n;
        begin
            @(posedge clk);
            adr <= a;
            rd <= !w;
            wr <= w;
            wd <= d;
            tmo = 1'b1;
            q = 32'h0;
            r = 2'h0;
            for (n = 0; n < 40 && tmo; n = n + 1)
            begin
                @(posedge clk);
                if (!wreq)
                begin
                    tmo = 1'b0;
                    q = rdat;
                    r = resp;
                end
            end
            rd <= 1'b0;
            wr <= 1'b0;
            wd <= ~d;
            adr <= ~a;
        end
    endtask
endmodule // ffma_host

/* File: dv/test_fault_flag_mask_aggregator.sv */
// Self-checking bench of the fault mask aggregator
`timescale 1ns/100ps
module test_fault_flag_mask_aggregator;
    // ----------
    // Stimulus
    // ----------
    reg         clk = 1'b0;
    reg         nrst = 1'b0;
    reg  [15:0] src = 16'h0;
    reg         ce = 1'b1;
    reg  [3:0]  be = 4'hF;
    reg  [15:0] bl;
    reg  [15:0] lf = 16'h676F;
    reg  [15:0] sh [0:3];
    reg  [31:0] q;
    reg  [1:0]  r;
    reg  [3:0]  e;
    integer     failures = 0;
    integer     cmp_count = 0;
    integer     i;
    integer     j;
    wire [31:0] wd, rdat;
    wire [9:0]  adr;
    wire [1:0]  resp;
    wire        rd, wr, wreq, tmo, int_f, occ_f, pin;
    always #4 clk = ~clk;
    ffma_host u_ffma_host
    (
        .clk(clk), .adr(adr), .rd(rd), .wr(wr), .wd(wd),
        .rdat(rdat), .wreq(wreq), .resp(resp), .tmo(tmo)
    );
    // Sources in raw status order; bits 13 and 12 are summaries and unused
    ffma_top u_ffma_top
    (
        .CLK_SYS(clk), .NRST(nrst), .CE(ce), .AVS_ADDRESS(adr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat),
        .AVS_WAITREQUEST(wreq), .AVS_RESPONSE(resp), .CFG_SECTION_ONE_CHECK_ERR(src[7]),
        .CFG_SECTION_TWO_CHECK_ERR(src[6]), .CFG_SECTION_THREE_CHECK_ERR(src[5]),
        .MEMORY_IMAGE_CHECK_ERR(src[4]), .CONV_A_HIGH_TRIP(src[3]), .CONV_A_LOW_TRIP(src[2]),
        .CONV_B_HIGH_TRIP(src[1]), .CONV_B_LOW_TRIP(src[0]), .POWER_RAIL_ERR(src[15]),
        .TIMEBASE_ERR(src[14]), .SERIAL_CHECK_ERR(src[11]), .SERIAL_IDLE_EXPIRY(src[10]),
        .SERIAL_EDGE_COUNT_ERR(src[9]), .ILLEGAL_ACCESS_ERR(src[8]),
        .INTEGRITY_SUMMARY_FLAG(int_f), .OVERCURRENT_SUMMARY_FLAG(occ_f), .SHARED_ALARM_PIN(pin)
    );
    // Helpers: random source, register address and writable bits, outputs
    function [15:0] lfsr(input [15:0] v);
        lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function [9:0] ra(input [1:0] k);
        ra = (k == 2'h3) ? 10'h144 : 10'h124 + {6'h0, k, 2'h0};
    endfunction
    function [15:0] wm(input [1:0] k);
        wm = (k == 2'h0) ? 16'hE800 : (k == 2'h1) ? 16'h000F : (k == 2'h2) ? 16'h7F80 : 16'h0001;
    endfunction
    // Pin split into status half and serial half so each can be judged alone
    function [3:0] ex(input [15:0] s);
        reg ie;
        reg oe;
        begin
            ie = |(s[7:4] & ~{sh[0][15:13], sh[0][11]});
            oe = |(s[3:0] & ~sh[1][3:0]);
            ex = {ie, oe, sh[3][0] & |({s[15:14], ie, oe} & ~sh[2][14:11]),
                  sh[3][0] & |(s[11:8] & ~sh[2][10:7])};
        end
    endfunction
    task final_report;
        begin
            if (failures == 0 && cmp_count > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp)
            begin
                failures = failures + 1;
                $display("[ERR] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // A bus cycle with no answer ends the run
    task acc(input w, input [9:0] a, input [31:0] d);
        begin
            u_ffma_host.xfer(w, a, d, q, r);
            if (tmo)
            begin
                failures = failures + 1;
                final_report;
            end
        end
    endtask
    // Reset values, all-ones writes, unmapped access, then random masks and faults
    initial
    begin
        sh[0] = 16'h0000;
        sh[1] = 16'h0000;
        sh[2] = 16'h0780;
        sh[3] = 16'h0000;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        for (j = 0; j < 4; j = j + 1)
        begin
            acc(1'b0, ra(j[1:0]), 32'h0);
            chk(q, {16'h0, sh[j]});
            acc(1'b1, ra(j[1:0]), 32'hFFFFFFFF);
            sh[j] = wm(j[1:0]);
        end
        acc(1'b1, 10'h3FC, 32'hFFFFFFFF);
        acc(1'b0, 10'h3FC, 32'h0);
        chk({q[31:2], r}, 32'h3);
        e = 4'h0;
        for (i = 0; i < 200; i = i + 1)
        begin
            lf = lfsr(lf);
            j = lf[1:0];
            acc(1'b0, ra(j[1:0]), 32'h0);
            chk(q, {16'h0, sh[j]});
            lf = lfsr(lf);
            // Random byte lanes; a lane left low keeps its old bits
            bl = {{8{lf[9]}}, {8{lf[8]}}} & wm(j[1:0]);
            be <= {2'h3, lf[9:8]};
            acc(1'b1, ra(j[1:0]), {lf, lf});
            sh[j] = (sh[j] & ~bl) | (lf & bl);
            // Summaries already follow the new masks; then freeze and move sources
            e = ex(src);
            lf = lfsr(lf);
            ce <= 1'b0;
            src <= lf;
            repeat (3) @(posedge clk);
            chk({31'h0, int_f}, {31'h0, e[3]});
            chk({31'h0, occ_f}, {31'h0, e[2]});
            ce <= 1'b1;
            repeat (3) @(posedge clk);
            e = ex(lf);
            chk({31'h0, int_f}, {31'h0, e[3]});
            chk({31'h0, occ_f}, {31'h0, e[2]});
            if (!e[0]) chk({31'h0, pin}, {31'h0, e[1]});
            if (!e[1]) chk({31'h0, pin}, {31'h0, e[0]});
            acc(1'b0, 10'h140, 32'h0);
            chk(q, {16'h0, lf[15:14], e[3:2], lf[11:0]});
        end
        final_report;
    end
endmodule // test_fault_flag_mask_aggregator
